// >>> include/wcu_defines.vh
`ifndef WCU_DEFINES_VH
`define WCU_DEFINES_VH

// special function register address of watchdog_control
`define WCU_CTRL_ADDR 8'h97
`define WCU_CTRL_RESET 8'h0B

// field positions
`define WCU_INTV_MSB 2
`define WCU_BIT_ACTIVE 4
`define WCU_BIT_CMD 7
`define WCU_BIT_FIXED 3

// write key codes
`define WCU_KEY_RELOAD 8'hA5
`define WCU_KEY_DIS1 8'hDE
`define WCU_KEY_DIS2 8'hAD
`define WCU_KEY_LOCK 8'hFF

// disable window in system clocks
`define WCU_DIS_WINDOW 3'h4

// interval exponent offset: timeout = 4^(code + offset) oscillator periods
`define WCU_INTV_EXP_OFS 5'h03

// length of the forced system reset pulse in system clocks
`define WCU_RST_PULSE 4'h8

`endif

// >>> hdl/wcu_lfo_tick.v
`default_nettype none
`include "wcu_defines.vh"

module wcu_lfo_tick #(
	parameter CNT_W = 21
) (
	input wire clk_sys_in,
	input wire rst_in,
	input wire osc_in,
	input wire run_in,
	input wire clear_in,
	input wire [2:0] code_in,
	output reg ovf_out
);

	reg sync1_r;
	reg sync2_r;
	reg sync3_r;
	reg lvl_r;
	reg [CNT_W-1:0] cnt_r;
	wire agree;
	wire rise;
	wire [CNT_W-1:0] lim;

	// 4^(code+3) = 2^(2*code+6) oscillator periods
	function [CNT_W-1:0] wcu_limit;
		input [2:0] code;
		reg [4:0] sh;
		begin
			sh = {1'b0, code, 1'b0} + (`WCU_INTV_EXP_OFS << 1);
			wcu_limit = {{(CNT_W-1){1'b0}}, 1'b1} << sh;
		end
	endfunction

	assign lim = wcu_limit(code_in);
	assign agree = (sync2_r == sync3_r);
	assign rise = agree && sync2_r && !lvl_r;

	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			sync3_r <= 1'b0;
			lvl_r <= 1'b0;
		end else begin
			sync1_r <= osc_in;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			if (agree) begin
				lvl_r <= sync2_r;
			end
		end
	end

	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_r <= {CNT_W{1'b0}};
			ovf_out <= 1'b0;
		end else begin
			ovf_out <= 1'b0;
			if (clear_in || !run_in) begin
				cnt_r <= {CNT_W{1'b0}};
			end else if (rise) begin
				if (cnt_r >= lim - {{(CNT_W-1){1'b0}}, 1'b1}) begin
					cnt_r <= {CNT_W{1'b0}};
					ovf_out <= 1'b1;
				end else begin
					cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end

endmodule // wcu_lfo_tick

`default_nettype wire

// >>> hdl/wcu_watchdog.v
`default_nettype none
`include "wcu_defines.vh"

module wcu_watchdog #(
	parameter CNT_W = 21
) (
	input wire clk_sys_in,
	input wire rst_in,
	input wire [7:0] sfr_addr_in,
	input wire sfr_wr_in,
	input wire [7:0] sfr_wdata_in,
	input wire sfr_rd_in,
	output reg [7:0] sfr_rdata_out,
	input wire low_freq_osc_in,
	output reg low_freq_osc_force_on_out,
	output reg supervisor_timer_active_out,
	output reg sys_reset_out
);

	// reset image of the control register, split into its fields
	localparam [7:0] CTRL_RST = `WCU_CTRL_RESET;
	localparam [2:0] INTV_RST = CTRL_RST[`WCU_INTV_MSB:0];
	localparam [0:0] FIXED_RD = CTRL_RST[`WCU_BIT_FIXED];

	// decoded write commands
	localparam [2:0] CMD_NONE = 3'h0;
	localparam [2:0] CMD_INTV = 3'h1;
	localparam [2:0] CMD_RELOAD = 3'h2;
	localparam [2:0] CMD_DIS1 = 3'h3;
	localparam [2:0] CMD_DIS2 = 3'h4;
	localparam [2:0] CMD_LOCK = 3'h5;

	reg [2:0] intv_r;
	reg [2:0] intv_nxt;
	reg active_r;
	reg active_nxt;
	reg lock_r;
	reg lock_nxt;
	reg [2:0] win_r;
	reg [2:0] win_nxt;
	reg [3:0] rstcnt_r;
	reg [3:0] rstcnt_nxt;
	reg clear_r;
	reg clear_nxt;
	reg [7:0] rdata_nxt;
	reg sys_reset_nxt;
	wire wr_hit;
	wire rd_hit;
	wire win_open;
	wire [2:0] wr_cmd;
	wire ovf;
	wire [7:0] rd_val;

	// register select, shared by the read and the write path
	function wcu_ctrl_hit;
		input [7:0] addr;
		begin
			wcu_ctrl_hit = (addr == `WCU_CTRL_ADDR);
		end
	endfunction

	// bit 7 clear sets the interval, otherwise only the key bytes act
	function [2:0] wcu_cmd_decode;
		input [7:0] data;
		begin
			if (!data[`WCU_BIT_CMD]) begin
				wcu_cmd_decode = CMD_INTV;
			end else if (data == `WCU_KEY_RELOAD) begin
				wcu_cmd_decode = CMD_RELOAD;
			end else if (data == `WCU_KEY_DIS1) begin
				wcu_cmd_decode = CMD_DIS1;
			end else if (data == `WCU_KEY_DIS2) begin
				wcu_cmd_decode = CMD_DIS2;
			end else if (data == `WCU_KEY_LOCK) begin
				wcu_cmd_decode = CMD_LOCK;
			end else begin
				wcu_cmd_decode = CMD_NONE;
			end
		end
	endfunction

	assign wr_hit = sfr_wr_in && wcu_ctrl_hit(sfr_addr_in);
	assign rd_hit = sfr_rd_in && wcu_ctrl_hit(sfr_addr_in);
	assign wr_cmd = wcu_cmd_decode(sfr_wdata_in);
	assign win_open = (win_r != 3'h0);
	assign rd_val = {3'h0, active_r, FIXED_RD, intv_r};

	wcu_lfo_tick #(
		.CNT_W(CNT_W)
	) u_tick (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.osc_in(low_freq_osc_in),
		.run_in(active_r),
		.clear_in(clear_r),
		.code_in(intv_r),
		.ovf_out(ovf)
	);

	// next state of the control logic
	always @* begin
		intv_nxt = intv_r;
		active_nxt = active_r;
		lock_nxt = lock_r;
		win_nxt = win_r;
		clear_nxt = 1'b0;
		rstcnt_nxt = rstcnt_r;
		if (rstcnt_r != 4'h0) begin
			rstcnt_nxt = rstcnt_r - 4'h1;
		end
		if (win_open) begin
			win_nxt = win_r - 3'h1;
		end
		if (ovf) begin
			// overflow restarts the block as a system reset would
			intv_nxt = INTV_RST;
			active_nxt = 1'b1;
			lock_nxt = 1'b0;
			win_nxt = 3'h0;
			clear_nxt = 1'b1;
			rstcnt_nxt = `WCU_RST_PULSE;
		end else if (wr_hit) begin
			// any write closes an open disable window unless it opens a new one
			win_nxt = 3'h0;
			case (wr_cmd)
				CMD_INTV: begin
					intv_nxt = sfr_wdata_in[`WCU_INTV_MSB:0];
				end
				CMD_RELOAD: begin
					active_nxt = 1'b1;
					clear_nxt = 1'b1;
				end
				CMD_DIS1: begin
					win_nxt = `WCU_DIS_WINDOW;
				end
				CMD_DIS2: begin
					// second key counts only inside the window and while unlocked
					if (win_open && !lock_r) begin
						active_nxt = 1'b0;
					end
				end
				CMD_LOCK: begin
					lock_nxt = 1'b1;
				end
				default: begin
					lock_nxt = lock_r;
				end
			endcase
		end
	end

	// read data stand for one cycle after a read, zero otherwise
	always @* begin
		rdata_nxt = 8'h00;
		if (rd_hit) begin
			rdata_nxt = rd_val;
		end
	end

	// reset request: in the cycle of overflow, then while the pulse counter is above 1
	always @* begin
		sys_reset_nxt = ovf || (rstcnt_r > 4'h1);
	end

	// interval code and disable lock
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			intv_r <= INTV_RST;
			lock_r <= 1'b0;
		end else begin
			intv_r <= intv_nxt;
			lock_r <= lock_nxt;
		end
	end

	// run state and count clear; a reset leaves the timer running from zero
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			active_r <= 1'b1;
			clear_r <= 1'b1;
		end else begin
			active_r <= active_nxt;
			clear_r <= clear_nxt;
		end
	end

	// disable window and reset pulse counters
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			win_r <= 3'h0;
			rstcnt_r <= 4'h0;
		end else begin
			win_r <= win_nxt;
			rstcnt_r <= rstcnt_nxt;
		end
	end

	// every output leaves straight from a flip-flop
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			sfr_rdata_out <= 8'h00;
			low_freq_osc_force_on_out <= 1'b1;
			supervisor_timer_active_out <= 1'b1;
			sys_reset_out <= 1'b0;
		end else begin
			sfr_rdata_out <= rdata_nxt;
			low_freq_osc_force_on_out <= active_r;
			supervisor_timer_active_out <= active_r;
			sys_reset_out <= sys_reset_nxt;
		end
	end

endmodule // wcu_watchdog

`default_nettype wire

// >>> verification/wcu_checker.sv
`default_nettype none
module wcu_checker (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic sfr_rd_in,
	input wire logic [7:0] sfr_rdata_out,
	input wire logic low_freq_osc_force_on_out,
	input wire logic supervisor_timer_active_out,
	input wire logic sys_reset_out
);
	timeunit 1ns;
	timeprecision 1ns;
	wire rd_hit=sfr_rd_in&&sfr_addr_in==8'h97;
	wire wr_hit=sfr_wr_in&&sfr_addr_in==8'h97;
	wire key_a5=wr_hit&&sfr_wdata_in==8'hA5;
	wire act=supervisor_timer_active_out;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	a_read_fixed: assert property ($past(rd_hit) |-> sfr_rdata_out[7:5]==3'h0&&sfr_rdata_out[3])
		else $error("read fixed bits");
	a_read_idle: assert property (!$past(rd_hit) |-> sfr_rdata_out==8'h00) else $error("read idle");
	a_read_active: assert property ($past(rd_hit) |-> sfr_rdata_out[4]==act) else $error("read active");
	a_reload_on: assert property (key_a5 |-> ##2 act) else $error("reload");
	a_disable_cause: assert property ($fell(act) |-> $past(wr_hit&&sfr_wdata_in==8'hAD,2))
		else $error("disable");
	a_stay_off: assert property (!act&&!$past(key_a5)&&!key_a5 |=> !act) else $error("enabled");
	a_osc_forced: assert property (act |-> low_freq_osc_force_on_out) else $error("osc");
	a_pulse_len: assert property ($rose(sys_reset_out) |-> sys_reset_out[*8] ##1 !sys_reset_out)
		else $error("pulse");
	a_reset_cause: assert property ($rose(sys_reset_out) |-> $past(act)) else $error("cause");
	cover property ($rose(sys_reset_out));
	cover property ($fell(act));
	cover property (rd_hit ##1 sfr_rdata_out[2:0]==3'h7);
endmodule // wcu_checker
bind wcu_watchdog wcu_checker u_chk (
	.clk_sys_in(clk_sys_in),
	.rst_in(rst_in),
	.sfr_addr_in(sfr_addr_in),
	.sfr_wr_in(sfr_wr_in),
	.sfr_wdata_in(sfr_wdata_in),
	.sfr_rd_in(sfr_rd_in),
	.sfr_rdata_out(sfr_rdata_out),
	.low_freq_osc_force_on_out(low_freq_osc_force_on_out),
	.supervisor_timer_active_out(supervisor_timer_active_out),
	.sys_reset_out(sys_reset_out)
);
`default_nettype wire

// >>> verification/wcu_watchdog_tb.sv
`default_nettype none
module wcu_watchdog_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk=0, rst=1, wr=0, rd=0, osc=0, fon, act, srst;
	logic [7:0] adr=8'h97, wd=8'h00, rdat;
	int errors=0, checks=0, n, m;
	always #5 clk=~clk;
	always #50 osc=~osc;
	wcu_watchdog DUT (.clk_sys_in(clk), .rst_in(rst), .sfr_addr_in(adr), .sfr_wr_in(wr), .sfr_wdata_in(wd),
		.sfr_rd_in(rd), .sfr_rdata_out(rdat), .low_freq_osc_in(osc), .low_freq_osc_force_on_out(fon),
		.supervisor_timer_active_out(act), .sys_reset_out(srst));
	task chk(input logic [7:0] s, e);
		checks++;
		if (s!==e) begin
			errors++;
			$display("[ERR] %0t %h %h", $time, s, e);
		end
	endtask
	task w(input logic [7:0] x);
		@(negedge clk) wr=1;
		wd=x;
	endtask
	task r(input logic [7:0] x, e);
		@(negedge clk) wr=0;
		@(negedge clk) rd=1;
		adr=x;
		@(negedge clk) rd=0;
		adr=8'h97;
		chk(rdat, e);
	endtask
	task complete_run;
		$display("checks %0d errors %0d", checks, errors);
		if (errors==0&&checks>0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(negedge clk);
		rst=0;
		r(8'h97, 8'h1B);
		chk(8'(act), 8'h01);
		chk(8'(fon), 8'h01);
		chk(8'(srst), 8'h00);
		r(8'h98, 8'h00);
		for (int i=0; i<8; i++) begin
			w(8'(i));
			r(8'h97, 8'h18|8'(i));
		end
		w(8'hDE);
		w(8'hAD);
		r(8'h97, 8'h0F);
		chk(8'(act), 8'h00);
		chk(8'(fon), 8'h00);
		w(8'hA5);
		r(8'h97, 8'h1F);
		chk(8'(act), 8'h01);
		chk(8'(fon), 8'h01);
		w(8'hDE);
		w(8'h05);
		w(8'hAD);
		r(8'h97, 8'h1D);
		w(8'hDE);
		repeat (5) @(negedge clk) wr=0;
		w(8'hAD);
		r(8'h97, 8'h1D);
		w(8'hFF);
		w(8'hDE);
		w(8'hAD);
		r(8'h97, 8'h1D);
		w(8'h00);
		w(8'hA5);
		for (n=0; n<2000&&srst!==1'b1; n++) @(negedge clk) wr=0;
		if (n==2000) begin
			errors++;
		end else begin
			chk(8'(n>625&&n<660), 8'h01);
			for (m=0; m<20&&srst===1'b1; m++) @(negedge clk);
			chk(8'(m), 8'h08);
			repeat (10) @(negedge clk);
			w(8'hDE);
			w(8'hAD);
			r(8'h97, 8'h0B);
			chk(8'(act), 8'h00);
			w(8'hFF);
			@(negedge clk) rst=1;
			wr=0;
			repeat (2) @(negedge clk);
			rst=0;
			r(8'h97, 8'h1B);
			w(8'hDE);
			w(8'hAD);
			r(8'h97, 8'h0B);
		end
		complete_run;
	end
endmodule // wcu_watchdog_tb
`default_nettype wire
